// File: shared/irss_pkg.sv
// register map, field positions and reset values for interrupt routing and sysref alignment
// Functional notes
// - amp error b select: 0 pin a, 1 pin b
// - delay loop lost select bit 5 routes
// - delay loop locked select bit 4 routes
// - clock mult lost select bit 1 routes
// - clock mult locked select bit 0 routes
// - summary bit 0 ORs all event status
// - writing 1 to summary clears latched events
// - skip count rising sysref edges before aligning
// - jitter event when deviation exceeds tolerance
// - read-only rotation done flag, resets to 1
// - monitor mode flags jitter, never realigns
// - one-shot aligns once, then returns to monitor
// - enable low follows live, high latches/drives/clears
package irss_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_STATUS_JITTER = 8'h24;
	localparam logic [7:0] IDX_EVENT_ENABLE = 8'h22;
	localparam logic [7:0] IDX_STATUS_AMP = 8'h26;
	localparam logic [7:0] IDX_STATUS_CLK = 8'h27;
	localparam logic [7:0] IDX_SEL_JITTER = 8'h28;
	localparam logic [7:0] IDX_SEL_AMP = 8'h2a;
	localparam logic [7:0] IDX_SEL_CLK = 8'h2b;
	localparam logic [7:0] IDX_SUMMARY = 8'h2c;
	localparam logic [7:0] IDX_SKIP = 8'h36;
	localparam logic [7:0] IDX_TOLERANCE = 8'h39;
	localparam logic [7:0] IDX_MODE = 8'h3a;
	// positions in the internal event vector
	localparam int EV_PLL_LOCK = 0;
	localparam int EV_PLL_LOST = 1;
	localparam int EV_DLL_LOCK = 2;
	localparam int EV_DLL_LOST = 3;
	localparam int EV_AMP_B = 4;
	localparam int EV_JITTER = 5;
	localparam int EV_COUNT = 6;
	// bit positions inside the registers
	localparam int BIT_CLK_MULT_LOCKED = 0;
	localparam int BIT_CLK_MULT_LOST = 1;
	localparam int BIT_DELAY_LOCKED = 4;
	localparam int BIT_DELAY_LOST = 5;
	localparam int BIT_AMP_B = 0;
	localparam int BIT_JITTER_SEL = 4;
	localparam int BIT_JITTER_STATUS = 0;
	localparam int BIT_SUMMARY = 0;
	localparam int BIT_ROTATION_DONE = 4;
	localparam int BIT_ONE_SHOT = 1;
	localparam int TOL_W = 7;
	localparam int SKIP_W = 8;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic RST_ROTATION_DONE = 1'b1;
	localparam int SYSREF_PERIOD_DEF = 32;
endpackage

// File: logic/irss_sync.sv
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ns
module irss_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstN,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// the first stage feeds only the second
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// File: logic/irss_ctrl.sv
// interrupt pin routing, event latching and sysref alignment with an ahb-lite register slave
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
module irss_ctrl #(
	parameter int SYSREF_PERIOD = irss_pkg::SYSREF_PERIOD_DEF
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// live event conditions, asynchronous
	input wire logic clkMultLocked,
	input wire logic clkMultLost,
	input wire logic delayLoopLocked,
	input wire logic delayLoopLost,
	input wire logic ampErrorB,
	input wire logic sysrefIn,
	// interrupt pins and alignment strobe
	output logic interrupt_out_a_n,
	output logic interrupt_out_b_n,
	output logic alignPulse
);
	logic [1:0] rstPipe_reg;
	logic rstSyncN;
	logic [irss_pkg::EV_COUNT-1:0] syncIn;
	logic [irss_pkg::EV_COUNT-1:0] liveEv;
	logic [irss_pkg::EV_COUNT-1:0] status_reg;
	logic [irss_pkg::EV_COUNT-1:0] eventEnable_reg;
	logic [irss_pkg::EV_COUNT-1:0] pinSel_reg;
	logic [irss_pkg::EV_COUNT-1:0] clrMask;
	logic [irss_pkg::SKIP_W-1:0] skipCount_reg;
	logic [irss_pkg::SKIP_W-1:0] skipLeft_reg;
	logic [irss_pkg::TOL_W-1:0] tolerance_reg;
	logic oneShot_reg;
	logic rotDone_reg;
	logic jitterPulse_reg;
	logic sysrefPrev_reg;
	logic sysrefRise;
	logic [7:0] phase_reg;
	logic [7:0] deviation;
	logic wrPend_reg;
	logic [7:0] wrIdx_reg;
	logic rdSum_reg;
	logic addrPhase;
	logic addrHit;
	logic [7:0] addrIdx;
	logic [7:0] readByte;
	logic [7:0] wrByte;
	logic irqA;
	logic irqB;

	// map the four clock events onto their register bit layout
	function automatic logic [7:0] clkField(input logic [3:0] ev);
		logic [7:0] r;
		r = irss_pkg::RST_ZERO;
		r[irss_pkg::BIT_CLK_MULT_LOCKED] = ev[irss_pkg::EV_PLL_LOCK];
		r[irss_pkg::BIT_CLK_MULT_LOST] = ev[irss_pkg::EV_PLL_LOST];
		r[irss_pkg::BIT_DELAY_LOCKED] = ev[irss_pkg::EV_DLL_LOCK];
		r[irss_pkg::BIT_DELAY_LOST] = ev[irss_pkg::EV_DLL_LOST];
		return r;
	endfunction

	// inverse of clkField
	function automatic logic [3:0] clkBits(input logic [7:0] b);
		logic [3:0] e;
		e[irss_pkg::EV_PLL_LOCK] = b[irss_pkg::BIT_CLK_MULT_LOCKED];
		e[irss_pkg::EV_PLL_LOST] = b[irss_pkg::BIT_CLK_MULT_LOST];
		e[irss_pkg::EV_DLL_LOCK] = b[irss_pkg::BIT_DELAY_LOCKED];
		e[irss_pkg::EV_DLL_LOST] = b[irss_pkg::BIT_DELAY_LOST];
		return e;
	endfunction

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstPipe_reg <= 2'h0;
		end else begin
			rstPipe_reg <= {rstPipe_reg[0], 1'b1};
		end
	end
	assign rstSyncN = rstPipe_reg[1];

	// event pins and sysref come from other domains
	irss_sync #(.W(irss_pkg::EV_COUNT)) evSync (
		.clk(ref_clk),
		.rstN(rstSyncN),
		.d({sysrefIn, ampErrorB, delayLoopLost, delayLoopLocked, clkMultLost, clkMultLocked}),
		.q(syncIn)
	);
	assign liveEv = {jitterPulse_reg, syncIn[irss_pkg::EV_AMP_B:0]};

	// bus address phase decode
	assign addrPhase = hsel && htrans[1] && hready;
	assign addrHit = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
	assign addrIdx = haddr[9:2];
	assign wrByte = hwdata[7:0];

	// register read mux, unmapped and reserved bits read zero
	always_comb begin
		readByte = irss_pkg::RST_ZERO;
		unique case (addrIdx)
			irss_pkg::IDX_EVENT_ENABLE: readByte[irss_pkg::EV_COUNT-1:0] = eventEnable_reg;
			irss_pkg::IDX_SEL_JITTER: readByte[irss_pkg::BIT_JITTER_SEL] = pinSel_reg[irss_pkg::EV_JITTER];
			irss_pkg::IDX_SEL_AMP: readByte[irss_pkg::BIT_AMP_B] = pinSel_reg[irss_pkg::EV_AMP_B];
			irss_pkg::IDX_SEL_CLK: readByte = clkField(pinSel_reg[3:0]);
			irss_pkg::IDX_STATUS_JITTER: readByte[irss_pkg::BIT_JITTER_STATUS] = status_reg[irss_pkg::EV_JITTER];
			irss_pkg::IDX_STATUS_AMP: readByte[irss_pkg::BIT_AMP_B] = status_reg[irss_pkg::EV_AMP_B];
			irss_pkg::IDX_STATUS_CLK: readByte = clkField(status_reg[3:0]);
			irss_pkg::IDX_SUMMARY: readByte[irss_pkg::BIT_SUMMARY] = |status_reg;
			irss_pkg::IDX_SKIP: readByte = skipCount_reg;
			irss_pkg::IDX_TOLERANCE: readByte[irss_pkg::TOL_W-1:0] = tolerance_reg;
			irss_pkg::IDX_MODE: begin
				readByte[irss_pkg::BIT_ROTATION_DONE] = rotDone_reg;
				readByte[irss_pkg::BIT_ONE_SHOT] = oneShot_reg;
			end
			default: readByte = irss_pkg::RST_ZERO;
		endcase
		if (!addrHit) begin
			readByte = irss_pkg::RST_ZERO;
		end
	end

	// zero wait states, always okay; read data registered into the data phase
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= 32'h0;
			wrPend_reg <= 1'b0;
			wrIdx_reg <= 8'h00;
			rdSum_reg <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wrPend_reg <= addrPhase && hwrite && addrHit;
			rdSum_reg <= addrPhase && !hwrite && addrHit && (addrIdx == irss_pkg::IDX_SUMMARY);
			if (addrPhase) begin
				wrIdx_reg <= addrIdx;
				hrdata <= hwrite ? 32'h0 : {24'h0, readByte};
			end
		end
	end

	// write-one-to-clear mask from status writes and the summary bit
	always_comb begin
		clrMask = '0;
		if (wrPend_reg) begin
			unique case (wrIdx_reg)
				irss_pkg::IDX_STATUS_JITTER: clrMask[irss_pkg::EV_JITTER] = wrByte[irss_pkg::BIT_JITTER_STATUS];
				irss_pkg::IDX_STATUS_AMP: clrMask[irss_pkg::EV_AMP_B] = wrByte[irss_pkg::BIT_AMP_B];
				irss_pkg::IDX_STATUS_CLK: clrMask[3:0] = clkBits(wrByte);
				irss_pkg::IDX_SUMMARY: clrMask = {irss_pkg::EV_COUNT{wrByte[irss_pkg::BIT_SUMMARY]}};
				default: clrMask = '0;
			endcase
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			eventEnable_reg <= '0;
			pinSel_reg <= '0;
			skipCount_reg <= irss_pkg::RST_ZERO;
			tolerance_reg <= '0;
		end else if (wrPend_reg) begin
			unique case (wrIdx_reg)
				irss_pkg::IDX_EVENT_ENABLE: eventEnable_reg <= wrByte[irss_pkg::EV_COUNT-1:0];
				irss_pkg::IDX_SEL_JITTER: pinSel_reg[irss_pkg::EV_JITTER] <= wrByte[irss_pkg::BIT_JITTER_SEL];
				irss_pkg::IDX_SEL_AMP: pinSel_reg[irss_pkg::EV_AMP_B] <= wrByte[irss_pkg::BIT_AMP_B];
				irss_pkg::IDX_SEL_CLK: pinSel_reg[3:0] <= clkBits(wrByte);
				irss_pkg::IDX_SKIP: skipCount_reg <= wrByte;
				irss_pkg::IDX_TOLERANCE: tolerance_reg <= wrByte[irss_pkg::TOL_W-1:0];
				default: ;
			endcase
		end
	end

	// status: follows live while disabled, latches while enabled; a new event beats a clear
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			status_reg <= '0;
		end else begin
			for (int i = 0; i < irss_pkg::EV_COUNT; i++) begin
				if (eventEnable_reg[i]) begin
					status_reg[i] <= (status_reg[i] && !clrMask[i]) || liveEv[i];
				end else begin
					status_reg[i] <= liveEv[i];
				end
			end
		end
	end

	// only enabled latched events pull a pin; select 0 is pin a, 1 is pin b
	assign irqA = |(status_reg & eventEnable_reg & ~pinSel_reg);
	assign irqB = |(status_reg & eventEnable_reg & pinSel_reg);

	// pins registered so they never glitch
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			interrupt_out_a_n <= 1'b1;
			interrupt_out_b_n <= 1'b1;
		end else begin
			interrupt_out_a_n <= !irqA;
			interrupt_out_b_n <= !irqB;
		end
	end

	// sysref edge detect on the synchronised copy
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			sysrefPrev_reg <= 1'b0;
		end else begin
			sysrefPrev_reg <= syncIn[irss_pkg::EV_JITTER];
		end
	end
	assign sysrefRise = syncIn[irss_pkg::EV_JITTER] && !sysrefPrev_reg;

	// distance of the edge from the expected phase, either side; period above 256 not supported
	assign deviation = (phase_reg <= 8'(SYSREF_PERIOD / 2)) ? phase_reg : 8'(8'(SYSREF_PERIOD) - phase_reg);

	// expected-edge phase counter, restarted only by an alignment
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			phase_reg <= 8'h00;
		end else if (sysrefRise && oneShot_reg && skipLeft_reg == '0) begin
			// the aligning edge is phase 0, so the cycle after it is 1; a clean period then lands on 0
			phase_reg <= 8'h01;
		end else if (phase_reg == 8'(SYSREF_PERIOD - 1)) begin
			phase_reg <= 8'h00;
		end else begin
			phase_reg <= 8'(phase_reg + 8'h01);
		end
	end

	// monitor mode: flag late or early edges, never touch the phase
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			jitterPulse_reg <= 1'b0;
		end else begin
			jitterPulse_reg <= sysrefRise && !oneShot_reg && (deviation > {1'b0, tolerance_reg});
		end
	end

	// one-shot: skip edges, align once, drop back to monitor; a fresh arm wins over completion
	always_ff @(posedge ref_clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			oneShot_reg <= 1'b0;
			skipLeft_reg <= irss_pkg::RST_ZERO;
			rotDone_reg <= irss_pkg::RST_ROTATION_DONE;
			alignPulse <= 1'b0;
		end else begin
			alignPulse <= 1'b0;
			if (sysrefRise && oneShot_reg) begin
				if (skipLeft_reg != '0) begin
					skipLeft_reg <= skipLeft_reg - 8'h01;
				end else begin
					oneShot_reg <= 1'b0;
					rotDone_reg <= 1'b1;
					alignPulse <= 1'b1;
				end
			end
			if (wrPend_reg && wrIdx_reg == irss_pkg::IDX_MODE) begin
				oneShot_reg <= wrByte[irss_pkg::BIT_ONE_SHOT];
				if (wrByte[irss_pkg::BIT_ONE_SHOT]) begin
					skipLeft_reg <= skipCount_reg;
					rotDone_reg <= 1'b0;
				end
			end
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstSyncN);

	logic sumWrite;
	assign sumWrite = wrPend_reg && wrIdx_reg == irss_pkg::IDX_SUMMARY && wrByte[irss_pkg::BIT_SUMMARY];

	ampRouteB_a: assert property (
		status_reg[4] && eventEnable_reg[4] && pinSel_reg[4] |=> !interrupt_out_b_n)
		else $error("amp error b not routed to pin b");
	delayLostA_a: assert property (
		status_reg[3] && eventEnable_reg[3] && !pinSel_reg[3] |=> !interrupt_out_a_n)
		else $error("delay loop lost not routed to pin a");
	delayLockB_a: assert property (
		status_reg[2] && eventEnable_reg[2] && pinSel_reg[2] |=> !interrupt_out_b_n)
		else $error("delay loop locked not routed to pin b");
	multLostA_a: assert property (
		status_reg[1] && eventEnable_reg[1] && !pinSel_reg[1] |=> !interrupt_out_a_n)
		else $error("clock mult lost not routed to pin a");
	multLockB_a: assert property (
		status_reg[0] && eventEnable_reg[0] && pinSel_reg[0] |=> !interrupt_out_b_n)
		else $error("clock mult locked not routed to pin b");
	summaryOr_a: assert property (
		rdSum_reg |-> hrdata[0] == $past(|status_reg))
		else $error("summary read is not the or of status");
	summaryClear_a: assert property (
		sumWrite && liveEv == '0 |=> status_reg == '0 ##1 interrupt_out_a_n && interrupt_out_b_n)
		else $error("summary write did not clear events");
	skipCount_a: assert property (
		sysrefRise && oneShot_reg && skipLeft_reg != '0 && !wrPend_reg
		|=> oneShot_reg && skipLeft_reg == $past(skipLeft_reg) - 8'h01 && !alignPulse)
		else $error("skipped edge not counted");
	jitterFlag_a: assert property (
		sysrefRise && !oneShot_reg && deviation > {1'b0, tolerance_reg}
		|=> jitterPulse_reg ##1 (status_reg[5] || !$past(eventEnable_reg[5])))
		else $error("jitter beyond tolerance not flagged");
	rotationDone_a: assert property (
		$rose(rotDone_reg) |-> alignPulse && !oneShot_reg)
		else $error("rotation done without alignment");
	monitorNoAlign_a: assert property (
		!oneShot_reg |=> !alignPulse
		&& phase_reg == (($past(phase_reg) == 8'(SYSREF_PERIOD - 1)) ? 8'h00 : 8'($past(phase_reg) + 8'h01)))
		else $error("monitor mode realigned");
	oneShotAlign_a: assert property (
		sysrefRise && oneShot_reg && skipLeft_reg == '0 && !wrPend_reg
		|=> alignPulse && phase_reg == 8'h01 && !oneShot_reg && rotDone_reg)
		else $error("one-shot did not align once");
	followLive_a: assert property (
		eventEnable_reg == '0 |=> status_reg == $past(liveEv))
		else $error("disabled status not following live");
	ampRouteA_a: assert property (
		status_reg[irss_pkg::EV_AMP_B] && eventEnable_reg[irss_pkg::EV_AMP_B] && !pinSel_reg[irss_pkg::EV_AMP_B] |=> !interrupt_out_a_n)
		else $error("amp error b not routed to pin a");
	disabledQuiet_a: assert property (
		(status_reg & eventEnable_reg) == '0 |=> interrupt_out_a_n && interrupt_out_b_n)
		else $error("pin pulled with no enabled latched event");

	oneShotSeen_c: cover property (oneShot_reg ##[1:200] alignPulse);
	pinAFall_c: cover property ($fell(interrupt_out_a_n));
	summaryClear_c: cover property (sumWrite && status_reg != '0);
	jitterSeen_c: cover property (jitterPulse_reg);
	skipSeen_c: cover property (sysrefRise && oneShot_reg && skipLeft_reg != '0);
endmodule

// File: testbench/irss_far_end.sv
// far-end model: live event sources and a sysref source with movable phase
`timescale 1ns/1ns
module irss_far_end #(
	parameter int PERIOD = 8
) (
	// clock
	input wire logic ref_clk,
	// commands from the bench
	input wire logic sysRun,
	input wire logic [7:0] shift,
	input wire logic [4:0] evCmd,
	// lines into the device
	output logic clkMultLocked,
	output logic clkMultLost,
	output logic delayLoopLocked,
	output logic delayLoopLost,
	output logic ampErrorB,
	output logic sysrefIn
);
	int cnt = 0;
	// source phase parks at zero while idle, so no edge appears outside a run
	always @(posedge ref_clk) begin
		cnt <= (!sysRun || cnt == PERIOD - 1) ? 0 : cnt + 1;
	end
	// one-cycle pulse at the commanded phase; moving it models a jittered source
	always @(posedge ref_clk) begin
		sysrefIn <= sysRun && (cnt == int'(shift));
	end
	// live levels change just after the edge, as a real source would not care
	always @(posedge ref_clk) begin
		{ampErrorB, delayLoopLost, delayLoopLocked, clkMultLost, clkMultLocked} <= evCmd;
	end
endmodule

// File: testbench/tb_irq_routing_sysref_sync.sv
// self-checking bench for interrupt routing and sysref alignment
`timescale 1ns/1ns
module tb_irq_routing_sysref_sync;
	localparam int P = 8;
	localparam logic [7:0] RSI [6] = '{8'h2b, 8'h2c, 8'h36, 8'h39, 8'h3a, 8'h2a};
	localparam logic [7:0] RWI [6] = '{8'h2b, 8'h36, 8'h39, 8'h2a, 8'h28, 8'h22};
	localparam logic [7:0] SELI [5] = '{8'h2b, 8'h2b, 8'h2b, 8'h2b, 8'h2a};
	localparam int SELB [5] = '{0, 1, 4, 5, 0};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic clkMultLocked, clkMultLost, delayLoopLocked, delayLoopLost, ampErrorB, sysrefIn;
	logic interrupt_out_a_n;
	logic interrupt_out_b_n;
	logic alignPulse;
	logic sysRun = 1'b0;
	logic [7:0] shift = 8'h0;
	logic [4:0] evCmd = 5'h0;
	logic [31:0] rd;
	logic [31:0] v;
	int errors = 0;
	int tests_run = 0;
	int edges = 0;
	int alignCnt = 0;
	int skip;
	int tol;

	always #20 ref_clk = ~ref_clk;
	// raw source edges and alignment strobes, counted for the one-shot checks
	always @(posedge sysrefIn) edges++;
	always @(posedge ref_clk) if (alignPulse === 1'b1) alignCnt++;

	irss_ctrl #(.SYSREF_PERIOD(P)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .clkMultLocked(clkMultLocked), .clkMultLost(clkMultLost),
		.delayLoopLocked(delayLoopLocked), .delayLoopLost(delayLoopLost), .ampErrorB(ampErrorB),
		.sysrefIn(sysrefIn), .interrupt_out_a_n(interrupt_out_a_n), .interrupt_out_b_n(interrupt_out_b_n),
		.alignPulse(alignPulse));
	irss_far_end #(.PERIOD(P)) farEnd (.ref_clk(ref_clk), .sysRun(sysRun), .shift(shift), .evCmd(evCmd),
		.clkMultLocked(clkMultLocked), .clkMultLost(clkMultLost), .delayLoopLocked(delayLoopLocked),
		.delayLoopLost(delayLoopLost), .ampErrorB(ampErrorB), .sysrefIn(sysrefIn));

	function automatic logic [31:0] ra(input logic [7:0] idx);
		return {22'h0, idx, 2'b00};
	endfunction
	// writable bits of each register
	function automatic logic [31:0] mask(input logic [7:0] idx);
		case (idx)
			8'h2b: return 32'h33;
			8'h36: return 32'hff;
			8'h39: return 32'h7f;
			8'h28: return 32'h10;
			8'h22: return 32'h3f;
			default: return 32'h01;
		endcase
	endfunction
	// jitter flag expected for a phase offset d against tolerance t
	function automatic logic [31:0] jitExp(input int d, input int t);
		int dev;
		dev = (d < P - d) ? d : P - d;
		return {31'h0, dev > t};
	endfunction

	// one single ahb-lite transfer; entered and left just after a rising edge, no wait count assumed
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		// address phase stands until hready is seen high at a rising edge
		do begin
			@(posedge ref_clk);
		end while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		// data phase ends at the next edge with hready high; read data taken at that edge
		do begin
			@(posedge ref_clk);
		end while (hreadyout !== 1'b1);
		r = hrdata;
		chk({31'h0, hresp}, 32'h0, "response");
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// pin levels looked at mid-cycle, where they are settled
	task automatic pins(input logic a, input logic b);
		@(negedge ref_clk);
		chk({31'h0, interrupt_out_a_n}, {31'h0, a}, "pin a");
		chk({31'h0, interrupt_out_b_n}, {31'h0, b}, "pin b");
		@(posedge ref_clk);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// watchdog at ten thousand cycles, over ten times the expected run
	initial begin
		#400000;
		errors++;
		$display("Error at %0t: timeout", $time);
		stop_test();
	end

	initial begin
		void'($urandom(32'h8853));
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		// reset values, rotation done reads 1
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ra(RSI[i]), 32'h0, rd);
			chk(rd, (RSI[i] == 8'h3a) ? 32'h10 : 32'h0, "reset value");
		end
		// random write and read back through the writable bits
		for (int i = 0; i < 6; i++) begin
			v = {24'h0, 8'($urandom())};
			bus(1'b1, ra(RWI[i]), v, rd);
			bus(1'b0, ra(RWI[i]), 32'h0, rd);
			chk(rd, v & mask(RWI[i]), "read back");
		end
		// an unmapped write is dropped and reads 0
		bus(1'b1, 32'h400 | ra(8'h36), 32'h5a, rd);
		bus(1'b0, 32'h400 | ra(8'h36), 32'h0, rd);
		chk(rd, 32'h0, "unmapped");
		// every live event to each pin, latched, summarised, then cleared two ways
		for (int k = 0; k < 5; k++) begin
			for (int s = 0; s < 2; s++) begin
				bus(1'b1, ra(8'h22), 32'h1 << k, rd);
				bus(1'b1, ra(SELI[k]), s ? (32'h1 << SELB[k]) : 32'h0, rd);
				evCmd <= 5'h1 << k;
				repeat (6) @(posedge ref_clk);
				pins(logic'(s == 0) ? 1'b0 : 1'b1, logic'(s == 0) ? 1'b1 : 1'b0);
				evCmd <= 5'h0;
				repeat (6) @(posedge ref_clk);
				bus(1'b0, ra(k == 4 ? 8'h26 : 8'h27), 32'h0, rd);
				chk(rd, 32'h1 << SELB[k], "latched");
				bus(1'b0, ra(8'h2c), 32'h0, rd);
				chk(rd, 32'h1, "summary");
				bus(1'b1, s ? ra(k == 4 ? 8'h26 : 8'h27) : ra(8'h2c), s ? (32'h1 << SELB[k]) : 32'h1, rd);
				repeat (3) @(posedge ref_clk);
				pins(1'b1, 1'b1);
				bus(1'b0, ra(8'h2c), 32'h0, rd);
				chk(rd, 32'h0, "cleared");
			end
		end
		// a disabled event follows its live level and stays off the pins
		bus(1'b1, ra(8'h22), 32'h0, rd);
		evCmd <= 5'h10;
		repeat (6) @(posedge ref_clk);
		pins(1'b1, 1'b1);
		bus(1'b0, ra(8'h26), 32'h0, rd);
		chk(rd, 32'h1, "live high");
		evCmd <= 5'h0;
		repeat (6) @(posedge ref_clk);
		bus(1'b0, ra(8'h26), 32'h0, rd);
		chk(rd, 32'h0, "live low");
		// one-shot alignment after skipped edges, zero skip first
		tol = $urandom_range(3, 1);
		bus(1'b1, ra(8'h22), 32'h20, rd);
		bus(1'b1, ra(8'h28), 32'h10, rd);
		bus(1'b1, ra(8'h39), tol, rd);
		for (int r = 0; r < 2; r++) begin
			sysRun <= 1'b0;
			repeat (P) @(posedge ref_clk);
			skip = (r == 0) ? 0 : $urandom_range(4, 1);
			bus(1'b1, ra(8'h36), skip, rd);
			bus(1'b1, ra(8'h3a), 32'h2, rd);
			bus(1'b0, ra(8'h3a), 32'h0, rd);
			chk(rd, 32'h2, "armed");
			edges = 0;
			alignCnt = 0;
			sysRun <= 1'b1;
			for (int n = 0; n < 40 * P && alignCnt == 0; n++) @(posedge ref_clk);
			chk(edges, skip + 1, "edges to align");
			bus(1'b0, ra(8'h3a), 32'h0, rd);
			chk(rd, 32'h10, "done");
		end
		// monitor mode: moved edges flag jitter beyond the tolerance, no realignment
		bus(1'b1, ra(8'h2c), 32'h1, rd);
		alignCnt = 0;
		for (int d = 1; d < P; d++) begin
			shift <= 8'(d);
			repeat (3 * P) @(posedge ref_clk);
			bus(1'b0, ra(8'h24), 32'h0, rd);
			chk(rd, jitExp(d, tol), "jitter");
			pins(1'b1, jitExp(d, tol) == 32'h0);
			shift <= 8'h0;
			repeat (3 * P) @(posedge ref_clk);
			bus(1'b1, ra(8'h2c), 32'h1, rd);
		end
		chk(alignCnt, 0, "realigned");
		stop_test();
	end
endmodule
